// file: hdl/vcoc_consts.svh
// Constants for the oscillator control register bank.
// Assumes an 8-bit register port with a 10-bit address.
`ifndef VCOC_CONSTS_SVH
`define VCOC_CONSTS_SVH

// Register offsets
`define VCOC_OFS_OSC_CTRL 10'h0f3
`define VCOC_OFS_DIV_CTRL 10'h0f4
`define VCOC_OFS_LOOP_FILT 10'h0f5

// Reset values
`define VCOC_RST_OSC_CTRL 8'h00
`define VCOC_RST_DIV_CTRL 8'h00
`define VCOC_RST_LOOP_FILT 8'h00

// Writable bit masks, reserved bits are zero
`define VCOC_MASK_OSC_CTRL 8'h1e
`define VCOC_MASK_DIV_CTRL 8'h0f
`define VCOC_MASK_LOOP_FILT 8'hff

// Oscillator control fields
`define VCOC_BIT_FORCE_REL 4
`define VCOC_BIT_REF_OVR 3
`define VCOC_BIT_MIDSCALE 2
`define VCOC_BIT_CAL 1

// Divider control fields
`define VCOC_BIT_DIV_PD 3
`define VCOC_DIV_CODE_HI 2
`define VCOC_DIV_CODE_LO 0
`define VCOC_DIV_BASE 4'h4

// Loop filter fields
`define VCOC_POLE2_HI 7
`define VCOC_POLE2_LO 6
`define VCOC_ZERO_HI 5
`define VCOC_ZERO_LO 3

// Pole two resistor values in ohms
`define VCOC_POLE2_OHM_0 10'd900
`define VCOC_POLE2_OHM_1 10'd450
`define VCOC_POLE2_OHM_2 10'd300
`define VCOC_POLE2_OHM_3 10'd225

// Zero resistor values in ohms
`define VCOC_ZERO_OHM_0 12'd3250
`define VCOC_ZERO_OHM_1 12'd2750
`define VCOC_ZERO_OHM_2 12'd2250
`define VCOC_ZERO_OHM_3 12'd2100
`define VCOC_ZERO_OHM_4 12'd3000
`define VCOC_ZERO_OHM_5 12'd2500
`define VCOC_ZERO_OHM_6 12'd2000
`define VCOC_ZERO_OHM_7 12'd1850

`endif

// file: hdl/vcoc_osc_div.sv
// Shared oscillator divider, ratio code plus four, with power-down.
// Assumes code and power-down come from flops on the same clock.
`timescale 1ns/1ps
`include "vcoc_consts.svh"

module vcoc_osc_div (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic [2:0] div_code,
  input wire logic div_pd,
  // Output
  output logic div_out,
  output logic [3:0] div_ratio
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic div_d;
  logic [3:0] ratio;
  logic wrap;

  assign ratio = `VCOC_DIV_BASE + {1'b0, div_code};
  assign wrap = (cnt_q >= ratio - 4'h1);
  assign cnt_d = div_pd ? 4'h0 : (wrap ? 4'h0 : cnt_q + 4'h1);
  assign div_d = !div_pd && (cnt_d >= ratio - {1'b0, ratio[3:1]});
  assign div_ratio = ratio;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      div_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      div_out <= div_d;
    end
  end

endmodule

// file: hdl/vcoc_pkg.sv
// Types for the oscillator control register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package vcoc_pkg;

  typedef enum logic {
    SYNC_HELD,
    SYNC_FREE
  } vcoc_sync_state_type;

endpackage

// file: hdl/vcoc_top.sv
// Oscillator control register bank: sync release, reference valid,
// midscale, calibration, oscillator divider and loop filter decode.
// Assumes lock and valid indicators arrive asynchronously on pins.
`timescale 1ns/1ps
`include "vcoc_consts.svh"

module vcoc_top
  import vcoc_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  // Loop indicators from pins
  input wire logic out_synth_lock,
  input wire logic cleanup_osc_valid,
  // Distribution sync
  output logic dist_sync_hold,
  output logic dist_release_pulse,
  // Oscillator controls
  output logic ref_valid,
  output logic vco_midscale,
  output logic cal_start,
  output logic cal_active,
  // Divider
  output logic osc_div_out,
  output logic [3:0] osc_div_ratio,
  output logic osc_div_powered_down,
  // Loop filter
  output logic [9:0] pole_two_resistor_ohms,
  output logic [11:0] zero_resistor_value_ohms
);

  // Register storage
  logic [7:0] ctrl_q;
  logic [7:0] div_q;
  logic [7:0] filt_q;

  // Address decode
  logic sel_ctrl;
  logic sel_div;
  logic sel_filt;
  logic wr_ctrl;
  logic wr_div;
  logic wr_filt;
  logic [7:0] rd_mux;

  assign sel_ctrl = (reg_addr == `VCOC_OFS_OSC_CTRL);
  assign sel_div = (reg_addr == `VCOC_OFS_DIV_CTRL);
  assign sel_filt = (reg_addr == `VCOC_OFS_LOOP_FILT);
  assign wr_ctrl = reg_wr_en && sel_ctrl;
  assign wr_div = reg_wr_en && sel_div;
  assign wr_filt = reg_wr_en && sel_filt;
  assign rd_mux = sel_ctrl ? ctrl_q :
                  sel_div ? div_q :
                  sel_filt ? filt_q : 8'h00;

  // Register writes, reserved bits masked off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `VCOC_RST_OSC_CTRL;
      div_q <= `VCOC_RST_DIV_CTRL;
      filt_q <= `VCOC_RST_LOOP_FILT;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wr_data & `VCOC_MASK_OSC_CTRL;
      end
      if (wr_div) begin
        div_q <= reg_wr_data & `VCOC_MASK_DIV_CTRL;
      end
      if (wr_filt) begin
        filt_q <= reg_wr_data & `VCOC_MASK_LOOP_FILT;
      end
    end
  end

  // Read data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rd_data <= rd_mux;
    end
  end

  // Field views
  logic force_rel;
  logic ref_ovr;
  logic cal_bit;

  assign force_rel = ctrl_q[`VCOC_BIT_FORCE_REL];
  assign ref_ovr = ctrl_q[`VCOC_BIT_REF_OVR];
  assign cal_bit = ctrl_q[`VCOC_BIT_CAL];

  // Pin synchronisers, bit 1 lock, bit 0 cleanup indicator
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic lock_s;
  logic ind_s;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 2'b00;
      pin_sync_q <= 2'b00;
    end else begin
      pin_meta_q <= {out_synth_lock, cleanup_osc_valid};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign lock_s = pin_sync_q[1];
  assign ind_s = pin_sync_q[0];

  // Distribution sync release
  vcoc_sync_state_type state_q;
  vcoc_sync_state_type state_d;
  logic release_now;

  assign release_now = (state_q == SYNC_HELD) && (lock_s || force_rel);

  always_comb begin
    state_d = state_q;
    case (state_q)
      SYNC_HELD: begin
        if (release_now) begin
          state_d = SYNC_FREE;
        end
      end
      SYNC_FREE: begin
        state_d = SYNC_FREE;
      end
      default: begin
        state_d = SYNC_HELD;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SYNC_HELD;
      dist_release_pulse <= 1'b0;
    end else begin
      state_q <= state_d;
      dist_release_pulse <= release_now;
    end
  end

  assign dist_sync_hold = (state_q == SYNC_HELD);

  // Reference valid, midscale and calibration
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_valid <= 1'b0;
      vco_midscale <= 1'b0;
      cal_start <= 1'b0;
    end else begin
      ref_valid <= ref_ovr || ind_s;
      vco_midscale <= ctrl_q[`VCOC_BIT_MIDSCALE];
      cal_start <= wr_ctrl && reg_wr_data[`VCOC_BIT_CAL]
        && !cal_bit;
    end
  end

  assign cal_active = cal_bit;

  // Oscillator divider
  vcoc_osc_div u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .div_code(div_q[`VCOC_DIV_CODE_HI:`VCOC_DIV_CODE_LO]),
    .div_pd(div_q[`VCOC_BIT_DIV_PD]),
    .div_out(osc_div_out),
    .div_ratio(osc_div_ratio)
  );

  assign osc_div_powered_down = div_q[`VCOC_BIT_DIV_PD];

  // Loop filter decode
  function automatic logic [9:0] pole2_ohms(input logic [1:0] code);
    case (code)
      2'h0: pole2_ohms = `VCOC_POLE2_OHM_0;
      2'h1: pole2_ohms = `VCOC_POLE2_OHM_1;
      2'h2: pole2_ohms = `VCOC_POLE2_OHM_2;
      default: pole2_ohms = `VCOC_POLE2_OHM_3;
    endcase
  endfunction

  function automatic logic [11:0] zero_ohms(input logic [2:0] code);
    case (code)
      3'h0: zero_ohms = `VCOC_ZERO_OHM_0;
      3'h1: zero_ohms = `VCOC_ZERO_OHM_1;
      3'h2: zero_ohms = `VCOC_ZERO_OHM_2;
      3'h3: zero_ohms = `VCOC_ZERO_OHM_3;
      3'h4: zero_ohms = `VCOC_ZERO_OHM_4;
      3'h5: zero_ohms = `VCOC_ZERO_OHM_5;
      3'h6: zero_ohms = `VCOC_ZERO_OHM_6;
      default: zero_ohms = `VCOC_ZERO_OHM_7;
    endcase
  endfunction

  logic [1:0] pole2_code;
  logic [2:0] zero_code;

  assign pole2_code = filt_q[`VCOC_POLE2_HI:`VCOC_POLE2_LO];
  assign zero_code = filt_q[`VCOC_ZERO_HI:`VCOC_ZERO_LO];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pole_two_resistor_ohms <= `VCOC_POLE2_OHM_0;
      zero_resistor_value_ohms <= `VCOC_ZERO_OHM_0;
    end else begin
      pole_two_resistor_ohms <= pole2_ohms(pole2_code);
      zero_resistor_value_ohms <= zero_ohms(zero_code);
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_hold_until_lock;
    (dist_sync_hold && !lock_s && !force_rel) |=> dist_sync_hold;
  endproperty
  a_hold_until_lock: assert property (p_hold_until_lock)
    else $error("sync released without lock or force");

  property p_release_together;
    (dist_sync_hold && lock_s) |=> (!dist_sync_hold && dist_release_pulse)
      ##1 !dist_release_pulse;
  endproperty
  a_release_together: assert property (p_release_together)
    else $error("release on lock not a single pulse");

  property p_stay_released;
    !dist_sync_hold |=> !dist_sync_hold;
  endproperty
  a_stay_released: assert property (p_stay_released)
    else $error("distribution held again after release");

  property p_force_release;
    (wr_ctrl && reg_wr_data[`VCOC_BIT_FORCE_REL]) |=> ##1 !dist_sync_hold;
  endproperty
  a_force_release: assert property (p_force_release)
    else $error("force bit did not release distribution");

  property p_ref_follows_ind;
    (!ref_ovr && !cleanup_osc_valid)[*4] |-> !ref_valid;
  endproperty
  a_ref_follows_ind: assert property (p_ref_follows_ind)
    else $error("reference valid while indicator low");

  property p_ref_override;
    ref_ovr |=> ref_valid;
  endproperty
  a_ref_override: assert property (p_ref_override)
    else $error("override did not mark reference valid");

  property p_midscale;
    (wr_ctrl && reg_wr_data[`VCOC_BIT_MIDSCALE]) |=> ##1 vco_midscale;
  endproperty
  a_midscale: assert property (p_midscale)
    else $error("midscale not driven after write");

  property p_cal_start;
    (wr_ctrl && reg_wr_data[`VCOC_BIT_CAL] && !cal_bit) |=>
      (cal_start && cal_active);
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration start missing");

  property p_cal_sticky;
    (cal_active && !wr_ctrl) |=> (cal_active && !cal_start);
  endproperty
  a_cal_sticky: assert property (p_cal_sticky)
    else $error("calibrate bit cleared or restarted by itself");

  property p_div_by_four;
    ($rose(osc_div_out) && div_q[3:0] == 4'h0 && $past(div_q[3:0]) == 4'h0
      && $past(div_q[3:0], 2) == 4'h0) ##1
      (div_q[3:0] == 4'h0)[*4] |-> $rose(osc_div_out);
  endproperty
  a_div_by_four: assert property (p_div_by_four)
    else $error("divide by four period wrong");

  property p_div_pd;
    div_q[`VCOC_BIT_DIV_PD] |=> !osc_div_out;
  endproperty
  a_div_pd: assert property (p_div_pd)
    else $error("divider toggles while powered down");

  property p_pole2;
    (pole2_code == 2'h3) |=> (pole_two_resistor_ohms == 10'd225);
  endproperty
  a_pole2: assert property (p_pole2)
    else $error("pole two resistor decode wrong");

  property p_zero;
    (zero_code == 3'h2) |=> (zero_resistor_value_ohms == 12'd2250);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero resistor decode wrong");

  property p_reserved_zero;
    (reg_rd_en && sel_ctrl) |=> (reg_rd_data[7:5] == 3'h0 && !reg_rd_data[0]);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  c_release_lock: cover property (dist_sync_hold && lock_s && !force_rel);
  c_release_force: cover property (dist_sync_hold && force_rel && !lock_s);
  c_cal_start: cover property (cal_start);
  c_div_eleven: cover property ($rose(osc_div_out) && div_q[2:0] == 3'h7);

endmodule

// file: verif/tb.sv
// Self-checking bench for the oscillator control register bank.
// Assumes vcoc_top with its assertions; bench drives every input.
`timescale 1ns/1ps
`include "vcoc_consts.svh"

module tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wr_data = 8'h00;
  logic [7:0] reg_rd_data;
  logic out_synth_lock = 1'b0;
  logic cleanup_osc_valid = 1'b0;
  logic dist_sync_hold, dist_release_pulse, ref_valid, vco_midscale;
  logic cal_start, cal_active, osc_div_out, osc_div_powered_down;
  logic [3:0] osc_div_ratio;
  logic [9:0] pole_two_resistor_ohms;
  logic [11:0] zero_resistor_value_ohms;
  int failures = 0;
  int cmp_count = 0;
  int mdl [3];
  int msk [3] = '{`VCOC_MASK_OSC_CTRL, `VCOC_MASK_DIV_CTRL,
                  `VCOC_MASK_LOOP_FILT};
  int pole_t [4] = '{900, 450, 300, 225};
  int zero_t [8] = '{3250, 2750, 2250, 2100, 3000, 2500, 2000, 1850};
  int n;
  logic [7:0] d;

  vcoc_top #(.ADDR_W(10)) vcoc_top_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .out_synth_lock(out_synth_lock),
    .cleanup_osc_valid(cleanup_osc_valid),
    .dist_sync_hold(dist_sync_hold),
    .dist_release_pulse(dist_release_pulse), .ref_valid(ref_valid),
    .vco_midscale(vco_midscale), .cal_start(cal_start),
    .cal_active(cal_active), .osc_div_out(osc_div_out),
    .osc_div_ratio(osc_div_ratio),
    .osc_div_powered_down(osc_div_powered_down),
    .pole_two_resistor_ohms(pole_two_resistor_ohms),
    .zero_resistor_value_ohms(zero_resistor_value_ohms)
  );

  always #12.5 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    mdl = '{0, 0, 0};
  endtask

  // Write strobe for one cycle; model keeps writable bits only
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= v;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    if (a >= 10'h0f3 && a <= 10'h0f5) begin
      mdl[a - 10'h0f3] = v & msk[a - 10'h0f3];
    end
    #1;
  endtask

  task automatic rd_chk(input logic [9:0] a);
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    if (a >= 10'h0f3 && a <= 10'h0f5) begin
      check(reg_rd_data, mdl[a - 10'h0f3][7:0]);
    end else begin
      check(reg_rd_data, 8'h00);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // Cycles until the next rising edge of the divided output
  task automatic next_rise(output int k);
    logic prev;
    prev = osc_div_out;
    k = 0;
    do begin
      tick(1);
      k++;
      if (osc_div_out === 1'b1 && prev === 1'b0) break;
      prev = osc_div_out;
    end while (k < 40);
  endtask

  initial begin
    #(25ns * 20000);
    failures++;
    close_out();
  end

  initial begin
    void'($urandom(41));
    do_reset();
    tick(1);
    check(dist_sync_hold, 1'b1);
    check(osc_div_ratio, 4'h4);
    check(pole_two_resistor_ohms, 10'd900);
    check(zero_resistor_value_ohms, 12'd3250);
    for (int a = 10'h0f3; a <= 10'h0f6; a++) rd_chk(a[9:0]);
    // Reference valid follows the indicator
    tick(4);
    check(ref_valid, 1'b0);
    cleanup_osc_valid <= 1'b1;
    tick(5);
    check(ref_valid, 1'b1);
    cleanup_osc_valid <= 1'b0;
    // Reserved bits only: no release, reads zero
    wr(10'h0f3, 8'he1);
    tick(3);
    check(dist_sync_hold, 1'b1);
    rd_chk(10'h0f3);
    // First lock releases distribution once
    out_synth_lock <= 1'b1;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (dist_sync_hold !== 1'b0 && n < 8);
    check(n <= 4, 1'b1);
    check(dist_release_pulse, 1'b1);
    out_synth_lock <= 1'b0;
    tick(1);
    check(dist_release_pulse, 1'b0);
    tick(6);
    check(dist_sync_hold, 1'b0);
    // Random register traffic against the model
    repeat (4) begin
      for (int a = 10'h0f3; a <= 10'h0f6; a++) begin
        d = $urandom;
        wr(a[9:0], d);
        rd_chk(a[9:0]);
      end
    end
    wr(10'h0f3, 8'h04);
    tick(1);
    check(vco_midscale, 1'b1);
    wr(10'h0f3, 8'h00);
    tick(1);
    check(vco_midscale, 1'b0);
    check(cal_active, 1'b0);
    tick(4);
    check(ref_valid, 1'b0);
    wr(10'h0f3, 8'h08);
    tick(1);
    check(ref_valid, 1'b1);
    // Calibration start, no self-clear, restart after zero
    wr(10'h0f3, 8'h02);
    check(cal_start, 1'b1);
    tick(1);
    check(cal_start, 1'b0);
    wr(10'h0f3, 8'h02);
    check(cal_start, 1'b0);
    tick(6);
    check(cal_active, 1'b1);
    rd_chk(10'h0f3);
    wr(10'h0f3, 8'h00);
    wr(10'h0f3, 8'h02);
    check(cal_start, 1'b1);
    // Loop filter decode of every code
    for (int i = 0; i < 8; i++) begin
      wr(10'h0f5, {i[1:0], i[2:0], 3'($urandom)});
      tick(1);
      check(pole_two_resistor_ohms, pole_t[i % 4]);
      check(zero_resistor_value_ohms, zero_t[i]);
    end
    // Divider ratio, period and power-down
    for (int c = 0; c < 8; c++) begin
      wr(10'h0f4, {5'h00, c[2:0]});
      check(osc_div_ratio, c + 4);
      check(osc_div_powered_down, 1'b0);
      next_rise(n);
      next_rise(n);
      next_rise(n);
      check(n, c + 4);
      wr(10'h0f4, {5'h01, c[2:0]});
      tick(2);
      check(osc_div_powered_down, 1'b1);
      n = 0;
      repeat (12) begin
        tick(1);
        n += osc_div_out;
      end
      check(n, 0);
    end
    // Second reset, then forced release without lock
    do_reset();
    tick(1);
    check(dist_sync_hold, 1'b1);
    wr(10'h0f3, 8'h10);
    n = 0;
    while (dist_sync_hold !== 1'b0 && n < 8) begin
      tick(1);
      n++;
    end
    check(n <= 2, 1'b1);
    check(dist_release_pulse, 1'b1);
    close_out();
  end
endmodule
